// ==== src/ifvo_offset_mem.v ====
`timescale 1ns/1ps

// small offset store: one write port, two registered read ports
module ifvo_offset_mem #(
    parameter DEPTH = 191,
    parameter WIDTH = 17,
    parameter AW    = 8
) (
    // clock and reset
    input  wire             i_clock,
    input  wire             i_reset,
    // write port
    input  wire             i_wr_en,
    input  wire [AW-1:0]    i_wr_addr,
    input  wire [WIDTH-1:0] i_wr_data,
    // read port a, bus side
    input  wire [AW-1:0]    i_rd_addr_a,
    output reg  [WIDTH-1:0] o_rd_data_a,
    // read port b, core side
    input  wire [AW-1:0]    i_rd_addr_b,
    output reg  [WIDTH-1:0] o_rd_data_b
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    integer         k;

    // storage clears on reset, so no handler offset is ever unknown;
    // this costs flops instead of a ram macro
    always @(posedge i_clock) begin
        if (i_reset) begin
            for (k = 0; k < DEPTH; k = k + 1) begin
                mem[k] <= {WIDTH{1'b0}};
            end
        end else if (i_wr_en && (i_wr_addr < DEPTH)) begin
            mem[i_wr_addr] <= i_wr_data;
        end
    end

    // registered reads; out of range reads give zero
    always @(posedge i_clock) begin
        if (i_reset) begin
            o_rd_data_a <= {WIDTH{1'b0}};
            o_rd_data_b <= {WIDTH{1'b0}};
        end else begin
            o_rd_data_a <= (i_rd_addr_a < DEPTH) ? mem[i_rd_addr_a] : {WIDTH{1'b0}};
            o_rd_data_b <= (i_rd_addr_b < DEPTH) ? mem[i_rd_addr_b] : {WIDTH{1'b0}};
        end
    end

endmodule // ifvo_offset_mem

// ==== src/ifvo_regs.vh ====
`ifndef IFVO_REGS_VH
`define IFVO_REGS_VH

// bus byte address width in bits
`define IFVO_ADDR_W        10

// register byte addresses
`define IFVO_FLAG_BASE     10'h000
`define IFVO_ENABLE_BASE   10'h010
`define IFVO_OFFSET_BASE   10'h100

// companion address selectors, address bits [3:2]
`define IFVO_OP_WRITE      2'h0
`define IFVO_OP_CLEAR      2'h1
`define IFVO_OP_SET        2'h2
`define IFVO_OP_INVERT     2'h3

// handler offset register layout
`define IFVO_OFF_LSB       1
`define IFVO_OFF_MSB       17
`define IFVO_OFF_W         17

// vector count and index width
`define IFVO_NUM_VECTORS   191
`define IFVO_VEC_W         8

// reset values
`define IFVO_FLAG_RESET    32'h0000_0000
`define IFVO_ENABLE_RESET  32'h0000_0000
`define IFVO_OFFSET_RESET  17'h0_0000

`endif

// ==== src/ifvo_top.v ====
`timescale 1ns/1ps
`include "ifvo_regs.vh"

// Operation
// - flag bit reads one after request
// - enable bit gates its flag into pending, read/write
// - offset field bits 17..1 read/write
// - offset bit zero always reads zero
// - offset upper bits read zero, ignore writes
// - clear, set, invert companions at 4/8/c
module ifvo_top #(
    parameter NUM_SRC     = 32,
    parameter NUM_VECTORS = `IFVO_NUM_VECTORS
) (
    // clock and reset
    input  wire                    i_clock,
    input  wire                    i_reset,
    // register port
    input  wire [`IFVO_ADDR_W-1:0] i_addr,
    input  wire [31:0]             i_wdata,
    input  wire                    i_write,
    input  wire                    i_read,
    output wire [31:0]             o_rdata,
    // peripheral request pulses, same clock domain
    input  wire [NUM_SRC-1:0]      i_source_req,
    // towards the processor core
    output wire [NUM_SRC-1:0]      o_pending,
    output wire                    o_irq,
    // handler offset lookup by the core
    input  wire                    i_vec_lookup,
    input  wire [`IFVO_VEC_W-1:0]  i_vec_index,
    output wire [31:0]             o_vec_offset,
    output reg                     o_vec_valid
);

    // request_flag_bits and source_enable_bits
    reg  [NUM_SRC-1:0]     flag_register;
    reg  [NUM_SRC-1:0]     enable_register;
    reg  [NUM_SRC-1:0]     sw_flag;
    wire [NUM_SRC-1:0]     next_flag;
    reg  [NUM_SRC-1:0]     next_enable;

    // read path state
    reg  [31:0]            rdata_reg;
    reg                    rd_from_mem;

    // decode results
    wire                   hit_flag;
    wire                   hit_enable;
    wire                   hit_offset;
    wire [1:0]             op_sel;
    wire [`IFVO_VEC_W-1:0] off_index;
    wire [`IFVO_ADDR_W-1:0] off_rel;
    wire [`IFVO_OFF_W-1:0] off_rd_bus;
    wire [`IFVO_OFF_W-1:0] off_rd_core;
    wire                   off_wr_en;

    // apply one companion operation to a register value
    // a zero data bit leaves its register bit alone for clear, set and invert
    function [NUM_SRC-1:0] apply_op;
        input [1:0]         op;
        input [NUM_SRC-1:0] cur;
        input [NUM_SRC-1:0] data;
        begin
            case (op)
                `IFVO_OP_WRITE:  apply_op = data;
                `IFVO_OP_CLEAR:  apply_op = cur & ~data;
                `IFVO_OP_SET:    apply_op = cur | data;
                `IFVO_OP_INVERT: apply_op = cur ^ data;
                default:         apply_op = cur;
            endcase
        end
    endfunction

    // zero bits above the offset field in the register image
    localparam PAD_W = 32 - `IFVO_OFF_MSB - 1;

    // place a stored offset field into the 32-bit register image;
    // bit zero is a constant, so every handler offset is even
    function [31:0] offset_image;
        input [`IFVO_OFF_W-1:0] field;
        begin
            offset_image = {{PAD_W{1'b0}}, field, 1'b0};
        end
    endfunction

    // true when an address falls in the 16-byte group of a base;
    // the low four bits pick the companion and are ignored here
    function group_hit;
        input [`IFVO_ADDR_W-1:0] addr;
        input [`IFVO_ADDR_W-1:0] base;
        begin
            group_hit = (addr[`IFVO_ADDR_W-1:4] == base[`IFVO_ADDR_W-1:4]);
        end
    endfunction

    // address decode; each block spans one 16-byte group
    assign hit_flag   = group_hit(i_addr, `IFVO_FLAG_BASE);
    assign hit_enable = group_hit(i_addr, `IFVO_ENABLE_BASE);
    assign op_sel     = i_addr[3:2];

    // offset registers: one aligned word per vector
    // addresses below the base wrap in off_rel; the >= test keeps them out
    assign off_rel    = i_addr - `IFVO_OFFSET_BASE;
    assign off_index  = off_rel[`IFVO_ADDR_W-1:2];
    assign hit_offset = (i_addr >= `IFVO_OFFSET_BASE)
                        && (off_index < NUM_VECTORS)
                        && (i_addr[1:0] == 2'h0);

    // offset registers have no companions, so low bits must be zero
    assign off_wr_en  = i_write && hit_offset;

    // software view of the flag register: one companion op per write
    always @* begin
        sw_flag = flag_register;
        if (i_write && hit_flag) begin
            sw_flag = apply_op(op_sel, flag_register, i_wdata[NUM_SRC-1:0]);
        end
    end

    // per-source merge of hardware requests; a request in the cycle of a
    // software clear still lands, so no event is lost to that race
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g = g + 1) begin : g_src
            assign next_flag[g] = sw_flag[g] | i_source_req[g];
        end
    endgenerate

    // next enable value
    always @* begin
        next_enable = enable_register;
        if (i_write && hit_enable) begin
            next_enable = apply_op(op_sel, enable_register, i_wdata[NUM_SRC-1:0]);
        end
    end

    // flag and enable storage
    // enable doubles as the interrupt mask, so there is no separate mask
    always @(posedge i_clock) begin
        if (i_reset) begin
            flag_register   <= `IFVO_FLAG_RESET;
            enable_register <= `IFVO_ENABLE_RESET;
        end else begin
            flag_register   <= next_flag;
            enable_register <= next_enable;
        end
    end

    // level outputs: a pending bit falls at the edge of its mask write, or of its clear write if no request lands then; irq falls with the last pending bit
    // forward flag and enable
    assign o_pending = flag_register & enable_register;
    assign o_irq     = |o_pending;   // enable doubles as the mask

    // handler offset store, cleared on reset
    // port a serves the bus, port b the core, so a lookup never stalls a read;
    // out of range vectors read zero inside the store
    // offset field write
    ifvo_offset_mem #(
        .DEPTH (NUM_VECTORS),
        .WIDTH (`IFVO_OFF_W),
        .AW    (`IFVO_VEC_W)
    ) u_offset_mem (
        .i_clock     (i_clock),
        .i_reset     (i_reset),
        .i_wr_en     (off_wr_en),
        .i_wr_addr   (off_index),
        .i_wr_data   (i_wdata[`IFVO_OFF_MSB:`IFVO_OFF_LSB]),
        .i_rd_addr_a (off_index),
        .o_rd_data_a (off_rd_bus),
        .i_rd_addr_b (i_vec_index),
        .o_rd_data_b (off_rd_core)
    );

    // read capture for flag and enable; companions read the base value,
    // unmapped addresses read zero
    always @(posedge i_clock) begin
        if (i_reset) begin
            rdata_reg   <= 32'h0000_0000;
            rd_from_mem <= 1'b0;
        end else if (i_read) begin
            rd_from_mem <= hit_offset;
            if (hit_flag) begin
                rdata_reg <= flag_register;
            end else if (hit_enable) begin
                rdata_reg <= enable_register;
            end else begin
                rdata_reg <= 32'h0000_0000;
            end
        end else begin
            // read data stand only in the cycle after the strobe
            rdata_reg   <= 32'h0000_0000;
            rd_from_mem <= 1'b0;
        end
    end

    // both sources are flops; the select is a flop too
    // offset bit zero reads zero
    assign o_rdata = rd_from_mem ? offset_image(off_rd_bus) : rdata_reg;

    // core lookup: offset appears one cycle after the lookup strobe
    // a lookup in the cycle of an offset write still sees the old value
    always @(posedge i_clock) begin
        if (i_reset) begin
            o_vec_valid <= 1'b0;
        end else begin
            o_vec_valid <= i_vec_lookup;
        end
    end

    // gated to zero outside the valid cycle, like the bus read data
    // offset to core
    assign o_vec_offset = o_vec_valid ? offset_image(off_rd_core) : 32'h0000_0000;

endmodule // ifvo_top

// ==== tb/ifvo_src_model.sv ====
`timescale 1ns/1ps

// peripheral side: turns a bench command into one-cycle request pulses
module ifvo_src_model (
    // clock and command
    input  wire        i_clock,
    input  wire [31:0] i_fire,
    // request pulses towards the controller
    output reg  [31:0] o_source_req
);
    // registered, so pulses leave just after an edge like a real source
    always @(posedge i_clock) begin
        o_source_req <= i_fire;
    end
endmodule // ifvo_src_model

// ==== tb/ifvo_top_chk.sv ====
`timescale 1ns/1ps

// watches the top ports only
module ifvo_top_chk (
    // clock and reset
    input wire        i_clock,
    input wire        i_reset,
    // register port and core side
    input wire        i_read,
    input wire        i_write,
    input wire [31:0] o_rdata,
    input wire [31:0] o_pending,
    input wire        o_irq,
    input wire        i_vec_lookup,
    input wire [31:0] o_vec_offset,
    input wire        o_vec_valid
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);
    // irq is the or of the pending bits
    property p_irq; o_irq == (o_pending != 32'h0); endproperty
    a_irq: assert property (p_irq) else $error("irq differs from pending");
    // pending bits can only fall through a bus write
    property p_sticky; !i_write |=> (($past(o_pending) & ~o_pending) == 32'h0); endproperty
    a_sticky: assert property (p_sticky) else $error("pending fell alone");
    // pending and lookup valid clear on the first edge after reset
    property p_rst; $fell(i_reset) |-> o_pending == 32'h0 && !o_vec_valid; endproperty
    a_rst: assert property (p_rst) else $error("state not cleared");
    // read data only in the cycle after a read strobe
    property p_rd_idle; !i_read |=> o_rdata == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    // lookup answer exactly one cycle later
    property p_vvalid;
        i_vec_lookup |=> o_vec_valid ##1 (!o_vec_valid || $past(i_vec_lookup, 1));
    endproperty
    a_vvalid: assert property (p_vvalid) else $error("lookup answer late");
    // no valid without a lookup
    property p_vnone; !i_vec_lookup |=> !o_vec_valid; endproperty
    a_vnone: assert property (p_vnone) else $error("valid without lookup");
    // offset image is even with upper bits clear
    property p_vfmt; o_vec_offset[0] == 1'b0 && o_vec_offset[31:18] == 14'h0; endproperty
    a_vfmt: assert property (p_vfmt) else $error("offset image bad bits");
    // offset idle at zero outside valid
    property p_vidle; !o_vec_valid |-> o_vec_offset == 32'h0; endproperty
    a_vidle: assert property (p_vidle) else $error("offset without valid");
endmodule // ifvo_top_chk

bind ifvo_top ifvo_top_chk u_ifvo_top_chk (.i_clock, .i_reset, .i_read, .i_write, .o_rdata,
    .o_pending, .o_irq, .i_vec_lookup, .o_vec_offset, .o_vec_valid);

// ==== tb/test_ifvo_top.sv ====
`timescale 1ns/1ps

// flag, enable and offset scenarios
module test_ifvo_top;
    reg         i_clock = 1'b0;
    reg         i_reset = 1'b1;
    reg  [9:0]  i_addr = 10'h0;
    reg  [31:0] i_wdata = 32'h0;
    reg         i_write = 1'b0;
    reg         i_read = 1'b0;
    reg  [31:0] fire = 32'h0;
    reg         i_vec_lookup = 1'b0;
    reg  [7:0]  i_vec_index = 8'h0;
    wire [31:0] o_rdata, src, o_pending, o_vec_offset;
    wire        o_irq, o_vec_valid;
    integer     n_errors = 0, n_compared = 0, cyc = 0;
    always #5 i_clock = ~i_clock;
    ifvo_src_model u_ifvo_src_model (.i_clock, .i_fire(fire), .o_source_req(src));
    ifvo_top u_ifvo_top (.i_clock, .i_reset, .i_addr, .i_wdata, .i_write, .i_read, .o_rdata,
        .i_source_req(src), .o_pending, .o_irq, .i_vec_lookup, .i_vec_index,
        .o_vec_offset, .o_vec_valid);
    task print_verdict;
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task check(input [31:0] s, input [31:0] e);
        n_compared = n_compared + 1;
        if (s !== e) begin
            n_errors = n_errors + 1;
            $display("unexpected at %0t: saw %h wanted %h", $time, s, e);
        end
    endtask
    // bus cycles: strobes one cycle, read data sampled in the next
    task wr(input [9:0] a, input [31:0] d);
        @(posedge i_clock);
        i_write <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_write <= 1'b0;
        #1;
    endtask
    task rd(input [9:0] a, input [31:0] e);
        @(posedge i_clock);
        i_read <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_read <= 1'b0;
        #1 check(o_rdata, e);
    endtask
    task look(input [7:0] n, input [31:0] e);
        @(posedge i_clock);
        i_vec_lookup <= 1'b1;
        i_vec_index <= n;
        @(posedge i_clock);
        i_vec_lookup <= 1'b0;
        #1 check({31'h0, o_vec_valid}, 32'h1);
        check(o_vec_offset, e);
    endtask
    task t_reset;
        rd(10'h000, 32'h0);
        rd(10'h010, 32'h0);
        rd(10'h3f8, 32'h0);
        $display("test reset done");
    endtask
    task t_flags;
        @(posedge i_clock);
        fire <= 32'h8000_0008;
        @(posedge i_clock);
        fire <= 32'h0;
        rd(10'h000, 32'h8000_0008);
        wr(10'h010, 32'h8);
        check(o_pending, 32'h8);
        check({31'h0, o_irq}, 32'h1);
        wr(10'h004, 32'h8);
        check({31'h0, o_irq}, 32'h0);
        wr(10'h008, 32'h5);
        rd(10'h000, 32'h8000_0005);
        wr(10'h00c, 32'h8000_0001);
        rd(10'h00c, 32'h4);
        wr(10'h018, 32'hf0);
        wr(10'h014, 32'h8);
        wr(10'h01c, 32'hff);
        rd(10'h010, 32'h0f);
        check(o_pending, 32'h4);
        wr(10'h000, 32'h0);
        check({31'h0, o_irq}, 32'h0);
        $display("test flags done");
    endtask
    // a request and a software clear of the same flag meet at one edge
    task t_race;
        wr(10'h018, 32'h10);
        @(posedge i_clock);
        fire <= 32'h10;
        @(posedge i_clock);
        fire <= 32'h0;
        i_write <= 1'b1;
        i_addr <= 10'h004;
        i_wdata <= 32'h10;
        @(posedge i_clock);
        i_write <= 1'b0;
        #1 check(o_pending, 32'h10);
        wr(10'h004, 32'h10);
        check({31'h0, o_irq}, 32'h0);
        $display("test race done");
    endtask
    task t_offset;
        wr(10'h104, 32'hffff_ffff);
        rd(10'h104, 32'h0003_fffe);
        wr(10'h3f8, 32'h0001_2345);
        wr(10'h106, 32'h0);
        rd(10'h3f8, 32'h0001_2344);
        look(8'h01, 32'h0003_fffe);
        look(8'hbe, 32'h0001_2344);
        look(8'hbf, 32'h0);
        rd(10'h3fc, 32'h0);
        rd(10'h020, 32'h0);
        $display("test offset done");
    endtask
    // reset in mid-run clears flags, enables and the offset store
    task t_mid_reset;
        wr(10'h008, 32'h1);
        wr(10'h100, 32'h2);
        check({31'h0, o_irq}, 32'h1);
        rd(10'h100, 32'h2);
        @(posedge i_clock);
        i_reset <= 1'b1;
        repeat (3) @(posedge i_clock);
        i_reset <= 1'b0;
        #1 check(o_pending, 32'h0);
        rd(10'h000, 32'h0);
        rd(10'h010, 32'h0);
        rd(10'h100, 32'h0);
        look(8'h00, 32'h0);
        $display("test mid reset done");
    endtask
    // hang guard, well above the run length
    always @(posedge i_clock) begin
        cyc = cyc + 1;
        if (cyc == 600) begin
            n_errors = n_errors + 1;
            print_verdict;
        end
    end
    initial begin
        repeat (3) @(posedge i_clock);
        i_reset <= 1'b0;
        t_reset;
        t_flags;
        t_race;
        t_offset;
        t_mid_reset;
        print_verdict;
    end
endmodule // test_ifvo_top
